// ---- hdl/gsir_consts.svh ----
// Constants for the graphics status, interrupt and error report block
// Function
// - Any set error_identity bit drives the master error status bit.
// - A plane buffer switch command sets that plane's flip pending bit.
// - Next vertical blank of that plane clears its flip pending bit.
// - Unmasked flip pending bits latch identity on their falling edge.
// - Overlay switch sets overlay pending; overlay fetch in vblank clears it.
// - Pipe vblank status bit sets on leading edge of the pipe's vblank.
// - Software notify sets user notify bit without stall; no effect if set.
// - Pipeline notify sets only at pipeline end with flushes done.
// - Hot plug event sets the display port status bit.
// - Any change of a bit unmasked in status_write_mask triggers a write.
// - A status write stores the whole status vector at page dword 0.
// - Only bits unmasked in event_mask latch into event_identity.
// - Interrupt is high when any identity bit and its enable are set.
// - Error status bits are ORs of sources; three registers share layout.
// - Only error bits unmasked by error_report_mask enter error_identity.
// - error_identity bits persist until software clears them there.
// - Sync flush done clears sync enable and toggles sync status in the same cycle.
`ifndef GSIR_CONSTS_SVH
`define GSIR_CONSTS_SVH

`define GSIR_NBITS        13
`define GSIR_BIT_ERR      0
`define GSIR_BIT_THERM    1
`define GSIR_BIT_SYNC     2
`define GSIR_BIT_FLIP0    3
`define GSIR_BIT_OVL      7
`define GSIR_BIT_VBL0     8
`define GSIR_BIT_USER     10
`define GSIR_BIT_PIPE     11
`define GSIR_BIT_HOTPLUG  12

`define GSIR_OFF_RAW      12'h000
`define GSIR_OFF_WMASK    12'h004
`define GSIR_OFF_IDENT    12'h008
`define GSIR_OFF_EMASK    12'h00c
`define GSIR_OFF_EN       12'h010
`define GSIR_OFF_ERRSTAT  12'h014
`define GSIR_OFF_ERRMASK  12'h018
`define GSIR_OFF_ERRID    12'h01c
`define GSIR_OFF_PAGE     12'h020
`define GSIR_OFF_MODE     12'h024

`define GSIR_WMASK_RST    32'hffff_ffff
`define GSIR_EMASK_RST    32'hffff_ffff
`define GSIR_ERRMASK_RST  32'hffff_ffff
`define GSIR_RAW_W        13
`define GSIR_MODE_SYNC    0
`define GSIR_RESP_OKAY    2'h0
`define GSIR_RESP_DECERR  2'h3

`endif

// ---- hdl/gsir_pkg.sv ----
// Types for the graphics status, interrupt and error report block
package gsir_pkg;
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } gsir_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } gsir_axi_rsp_t;

  typedef struct packed {
    logic [3:0] flip_set;
    logic [3:0] flip_vblank;
    logic       ovl_set;
    logic       ovl_fetched;
    logic [1:0] pipe_vblank;
    logic       user_cmd;
    logic       pipe_notify_done;
    logic       hot_plug;
    logic       thermal_event;
    logic       sync_flush_done;
  } gsir_events_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        valid;
  } gsir_mem_wr_t;
endpackage

// ---- hdl/gsir_top.sv ----
// Status bit collection, status page writes, interrupt and error reporting
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gsir_consts.svh"
module gsir_top #(
  parameter int ERR_BITS = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire gsir_pkg::gsir_axi_req_t axi_req,
  output var  gsir_pkg::gsir_axi_rsp_t axi_rsp,
  input  wire gsir_pkg::gsir_events_t  events,
  input  wire logic [ERR_BITS-1:0]     err_sources,
  output var  gsir_pkg::gsir_mem_wr_t  mem_wr,
  input  wire logic                   mem_wr_ready,
  output var  logic                   sync_enable,
  output logic                        irq
);
  import gsir_pkg::*;

  // Error registers live in one 32-bit bus word
  if (ERR_BITS < 1 || ERR_BITS > 32) begin : g_err_bits_chk
    $error("ERR_BITS must be 1..32");
  end

  localparam int RW = `GSIR_RAW_W;

  typedef struct packed {
    logic [RW-1:0]       raw;
    logic [RW-1:0]       wmask;
    logic [RW-1:0]       ident;
    logic [RW-1:0]       emask;
    logic [RW-1:0]       en;
    logic [ERR_BITS-1:0] errmask;
    logic [ERR_BITS-1:0] errid;
    logic [31:0]         page;
    logic                sync_en;
    logic [1:0]          vbl_prev;
    logic                pend;
    gsir_mem_wr_t        mw;
    logic                aw_got;
    logic [11:0]         awaddr;
    logic                w_got;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } gsir_state_t;

  gsir_state_t st_r;
  gsir_state_t st_nxt;
  logic [ERR_BITS-1:0] err_stat;
  logic [RW-1:0]       raw_new;
  logic [RW-1:0]       fall_sel;
  logic [RW-1:0]       id_evt;

  assign err_stat = err_sources;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_reg(input gsir_state_t s, input logic [ERR_BITS-1:0] e, input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `GSIR_OFF_RAW:     v[RW-1:0] = s.raw;
      `GSIR_OFF_WMASK:   v[RW-1:0] = s.wmask;
      `GSIR_OFF_IDENT:   v[RW-1:0] = s.ident;
      `GSIR_OFF_EMASK:   v[RW-1:0] = s.emask;
      `GSIR_OFF_EN:      v[RW-1:0] = s.en;
      `GSIR_OFF_ERRSTAT: v[ERR_BITS-1:0] = e;
      `GSIR_OFF_ERRMASK: v[ERR_BITS-1:0] = s.errmask;
      `GSIR_OFF_ERRID:   v[ERR_BITS-1:0] = s.errid;
      `GSIR_OFF_PAGE:    v = s.page;
      `GSIR_OFF_MODE:    v[`GSIR_MODE_SYNC] = s.sync_en;
      default:           v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && a <= `GSIR_OFF_MODE;
  endfunction

  always_comb begin
    logic [31:0] wv;
    logic        wr_go;
    logic        rd_go;
    wv = 32'h0000_0000;
    wr_go = 1'b0;
    rd_go = 1'b0;
    st_nxt = st_r;

    // Status vector updates from hardware events
    raw_new = st_r.raw;
    for (int p = 0; p < 4; p++) begin
      if (events.flip_vblank[p]) raw_new[`GSIR_BIT_FLIP0+p] = 1'b0;
      if (events.flip_set[p]) raw_new[`GSIR_BIT_FLIP0+p] = 1'b1;
    end
    if (events.ovl_fetched) raw_new[`GSIR_BIT_OVL] = 1'b0;
    if (events.ovl_set) raw_new[`GSIR_BIT_OVL] = 1'b1;
    for (int v = 0; v < 2; v++) begin
      if (events.pipe_vblank[v] && !st_r.vbl_prev[v]) raw_new[`GSIR_BIT_VBL0+v] = 1'b1;
    end
    if (events.user_cmd) raw_new[`GSIR_BIT_USER] = 1'b1;
    if (events.pipe_notify_done) raw_new[`GSIR_BIT_PIPE] = 1'b1;
    if (events.hot_plug) raw_new[`GSIR_BIT_HOTPLUG] = 1'b1;
    if (events.thermal_event) raw_new[`GSIR_BIT_THERM] = 1'b1;
    // Parser clears sync enable in the same step as the toggle
    if (events.sync_flush_done && st_r.sync_en) begin
      raw_new[`GSIR_BIT_SYNC] = ~st_r.raw[`GSIR_BIT_SYNC];
      st_nxt.sync_en = 1'b0;
    end
    raw_new[`GSIR_BIT_ERR] = |st_r.errid;
    st_nxt.vbl_prev = events.pipe_vblank;

    // Flip and overlay bits capture on falling edge, others on rising
    fall_sel = '0;
    for (int p = 0; p < 4; p++) fall_sel[`GSIR_BIT_FLIP0+p] = 1'b1;
    fall_sel[`GSIR_BIT_OVL] = 1'b1;
    id_evt = ((st_r.raw & ~raw_new & fall_sel) | (~st_r.raw & raw_new & ~fall_sel)) & ~st_r.emask;

    // Status page write request; pend keeps a second write queued
    if (|((st_r.raw ^ raw_new) & ~st_r.wmask)) st_nxt.pend = 1'b1;
    if (st_r.mw.valid && mem_wr_ready) st_nxt.mw.valid = 1'b0;
    if (!st_nxt.mw.valid && st_nxt.pend) begin
      st_nxt.mw.valid = 1'b1;
      st_nxt.mw.addr = st_r.page;
      st_nxt.mw.data = 32'({raw_new});
      st_nxt.pend = 1'b0;
    end
    st_nxt.raw = raw_new;

    // AXI4-Lite write side
    if (axi_req.awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axi_req.wdata;
      st_nxt.wstrb = axi_req.wstrb;
    end
    wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(st_r.awaddr) ? `GSIR_RESP_OKAY : `GSIR_RESP_DECERR;
      wv = merge(32'h0000_0000, st_r.wdata, st_r.wstrb);
      unique case (st_r.awaddr)
        `GSIR_OFF_WMASK:   st_nxt.wmask = RW'(merge(32'(st_r.wmask), st_r.wdata, st_r.wstrb));
        `GSIR_OFF_EMASK:   st_nxt.emask = RW'(merge(32'(st_r.emask), st_r.wdata, st_r.wstrb));
        `GSIR_OFF_EN:      st_nxt.en = RW'(merge(32'(st_r.en), st_r.wdata, st_r.wstrb));
        `GSIR_OFF_ERRMASK: st_nxt.errmask = ERR_BITS'(merge(32'(st_r.errmask), st_r.wdata, st_r.wstrb));
        `GSIR_OFF_PAGE:    st_nxt.page = merge(st_r.page, st_r.wdata, st_r.wstrb) & 32'hffff_f000;
        `GSIR_OFF_MODE:    if (st_r.wstrb[0]) st_nxt.sync_en = st_r.wdata[`GSIR_MODE_SYNC];
        default:           ;
      endcase
    end
    if (st_r.bvalid && axi_req.bready) st_nxt.bvalid = 1'b0;

    // Identity registers: set wins over a write-one clear
    st_nxt.ident = st_r.ident;
    st_nxt.errid = st_r.errid;
    if (wr_go && st_r.awaddr == `GSIR_OFF_IDENT) st_nxt.ident = st_r.ident & ~RW'(wv);
    if (wr_go && st_r.awaddr == `GSIR_OFF_ERRID) st_nxt.errid = st_r.errid & ~ERR_BITS'(wv);
    st_nxt.ident = st_nxt.ident | id_evt;
    st_nxt.errid = st_nxt.errid | (err_stat & ~st_r.errmask);

    // AXI4-Lite read side
    rd_go = axi_req.arvalid && !st_r.rvalid;
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_reg(st_r, err_stat, axi_req.araddr);
      st_nxt.rresp = mapped(axi_req.araddr) ? `GSIR_RESP_OKAY : `GSIR_RESP_DECERR;
    end else if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.wmask <= RW'(`GSIR_WMASK_RST);
      st_r.emask <= RW'(`GSIR_EMASK_RST);
      st_r.errmask <= ERR_BITS'(`GSIR_ERRMASK_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = !st_r.aw_got;
    axi_rsp.wready = !st_r.w_got;
    axi_rsp.bvalid = st_r.bvalid;
    axi_rsp.bresp = st_r.bresp;
    axi_rsp.arready = !st_r.rvalid;
    axi_rsp.rvalid = st_r.rvalid;
    axi_rsp.rdata = st_r.rdata;
    axi_rsp.rresp = st_r.rresp;
  end

  assign mem_wr = st_r.mw;
  assign sync_enable = st_r.sync_en;
  assign irq = |(st_r.ident & st_r.en);
endmodule
`default_nettype wire

// ---- test/gsir_checker.sv ----
// Port assertions for the status block
`timescale 1ns/1ps
`default_nettype none
module gsir_checker #(parameter int ERR_BITS = 16) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire gsir_pkg::gsir_axi_req_t axi_req,
  input wire gsir_pkg::gsir_axi_rsp_t axi_rsp,
  input wire gsir_pkg::gsir_events_t  events,
  input wire logic [ERR_BITS-1:0]     err_sources,
  input wire gsir_pkg::gsir_mem_wr_t  mem_wr,
  input wire logic                    mem_wr_ready,
  input wire logic                    sync_enable,
  input wire logic                    irq
);
  import gsir_pkg::*;
  logic wrote_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Closed masks keep the block silent until software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wrote_r <= 1'b0;
    else if (axi_req.awvalid && axi_rsp.awready) wrote_r <= 1'b1;
  end
  sequence s_stall; mem_wr.valid && !mem_wr_ready; endsequence
  sequence s_aw; axi_req.awvalid && axi_rsp.awready; endsequence
  property p_wr_hold; s_stall |=> mem_wr.valid && $stable(mem_wr.data) && $stable(mem_wr.addr); endproperty
  property p_dw0; mem_wr.valid |-> mem_wr.addr[11:0] == 12'h000; endproperty
  property p_irq_quiet; !wrote_r |-> !irq; endproperty
  property p_wr_quiet; !wrote_r |-> !mem_wr.valid; endproperty
  property p_sync_clr; sync_enable && events.sync_flush_done |=> !sync_enable; endproperty
  property p_aw_block; s_aw |=> !axi_rsp.awready; endproperty
  property p_ar_block; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
  property p_rd_ans; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  property p_rd_done; axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write not held");
  a_dw0: assert property (p_dw0) else $error("write not at page dword 0");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq before setup");
  a_wr_quiet: assert property (p_wr_quiet) else $error("write while masked");
  a_sync_clr: assert property (p_sync_clr) else $error("sync enable kept");
  a_aw_block: assert property (p_aw_block) else $error("second address taken");
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rd_done: assert property (p_rd_done) else $error("read answer kept after taken");
endmodule
bind gsir_top gsir_checker #(.ERR_BITS(ERR_BITS)) i_gsir_checker (.clk(clk), .rst_n(rst_n), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .events(events), .err_sources(err_sources), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
  .sync_enable(sync_enable), .irq(irq));
`default_nettype wire

// ---- test/gsir_mem_model.sv ----
// Memory sink for status page writes
`timescale 1ns/1ps
`default_nettype none
module gsir_mem_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire gsir_pkg::gsir_mem_wr_t mem_wr,
  input  wire logic [31:0]            page,
  output var  logic                   ready,
  output var  logic [31:0]            dw0
);
  import gsir_pkg::*;
  // Random stalls make changes pile up behind a pending write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      dw0 <= '0;
    end else begin
      ready <= 1'($urandom_range(0, 1));
      if (mem_wr.valid && ready && mem_wr.addr == page) dw0 <= mem_wr.data;
    end
  end
endmodule
`default_nettype wire

// ---- test/gsir_top_test.sv ----
// Self-checking bench for the status block
`timescale 1ns/1ps
`default_nettype none
`include "gsir_consts.svh"
module gsir_top_test;
  import gsir_pkg::*;
  localparam int EM = 32'h800;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  gsir_axi_req_t q = '0;
  gsir_axi_rsp_t s;
  gsir_events_t  ev = '0;
  gsir_mem_wr_t  mw;
  logic [15:0]   errs = '0;
  logic [31:0]   dw0, page = '0;
  logic          rdy, sen, irq;
  int            fails = 0, num_checks = 0, raw = 0, idn = 0, k;
  always #5 clk = ~clk;
  gsir_top i_gsir_top (.clk(clk), .rst_n(rst_n), .axi_req(q), .axi_rsp(s), .events(ev), .err_sources(errs),
    .mem_wr(mw), .mem_wr_ready(rdy), .sync_enable(sen), .irq(irq));
  gsir_mem_model i_gsir_mem_model (.clk(clk), .rst_n(rst_n), .mem_wr(mw), .page(page), .ready(rdy), .dw0(dw0));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw, w, b = 1'b0;
    logic [1:0] rs;
    @(posedge clk);
    q <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hf, wvalid: 1'b1, bready: 1'b1, default: '0};
    while (!b) begin
      @(negedge clk);
      {aw, w, b, rs} = {s.awready, s.wready, s.bvalid, s.bresp};
      @(posedge clk);
      if (aw) q.awvalid <= 1'b0;
      if (w) q.wvalid <= 1'b0;
    end
    q.bready <= 1'b0;
    chk(32'({b, rs}), 32'({1'b1, er}));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    logic ar, r = 1'b0;
    logic [33:0] g;
    @(posedge clk);
    q <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
    while (!r) begin
      @(negedge clk);
      {ar, r, g} = {s.arready, s.rvalid, s.rresp, s.rdata};
      @(posedge clk);
      if (ar) q.arvalid <= 1'b0;
    end
    q.rready <= 1'b0;
    chk(32'({r, g[33:32]}), 32'({1'b1, er}));
    if (er == 2'h0) chk(g[31:0], exp);
  endtask
  // One event pulse, model update, raw status readback
  task automatic step(input int e, input int set, input int clr = 0);
    @(posedge clk);
    ev <= gsir_events_t'(e[16:0]);
    @(posedge clk);
    ev <= '0;
    // Flip and overlay bits report on their falling edge only
    idn |= ((set & ~raw & ~32'hf8) | (clr & raw & 32'hf8)) & ~EM;
    raw = (raw | set) & ~clr;
    rd(`GSIR_OFF_RAW, raw);
  endtask
  initial begin
    void'($urandom(32'h22c5));
    page = $urandom & 32'hffff_f000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`GSIR_OFF_WMASK, `GSIR_WMASK_RST & ((32'h1 << `GSIR_RAW_W) - 1));
    rd(12'h100, 0, `GSIR_RESP_DECERR);
    wr(12'h100, 1, `GSIR_RESP_DECERR);
    wr(`GSIR_OFF_PAGE, page);
    wr(`GSIR_OFF_WMASK, 32'h2);
    wr(`GSIR_OFF_EMASK, EM);
    wr(`GSIR_OFF_EN, 32'h1000);
    wr(`GSIR_OFF_ERRMASK, 32'h10);
    for (int i = 0; i < 4; i++) begin
      step(32'h2000 << i, 32'h8 << i);
      rd(`GSIR_OFF_IDENT, idn);
      step(32'h200 << i, 0, 32'h8 << i);
    end
    step(32'h100, 32'h80);
    step(32'h80, 0, 32'h80);
    step(32'h20, 32'h100);
    step(32'h40, 32'h200);
    step(32'h10, 32'h400);
    step(32'h10, 32'h400);
    step(32'h8, 32'h800);
    step(32'h2, 32'h2);
    step(32'h4, 32'h1000);
    rd(`GSIR_OFF_IDENT, idn);
    @(negedge clk);
    chk(32'(irq), 1);
    wr(`GSIR_OFF_IDENT, 0);
    rd(`GSIR_OFF_IDENT, idn);
    wr(`GSIR_OFF_IDENT, idn);
    idn = 0;
    rd(`GSIR_OFF_IDENT, 0);
    @(negedge clk);
    chk(32'(irq), 0);
    @(posedge clk);
    errs <= 16'h18;
    rd(`GSIR_OFF_ERRSTAT, 32'h18);
    errs <= 16'h0;
    rd(`GSIR_OFF_ERRID, 32'h8);
    raw |= 1;
    rd(`GSIR_OFF_RAW, raw);
    wr(`GSIR_OFF_ERRID, 32'h8);
    raw &= ~1;
    rd(`GSIR_OFF_RAW, raw);
    rd(`GSIR_OFF_IDENT, 1);
    wr(`GSIR_OFF_MODE, 1);
    @(negedge clk);
    chk(32'(sen), 1);
    step(1, 32'h4);
    rd(`GSIR_OFF_MODE, 0);
    @(negedge clk);
    chk(32'(sen), 0);
    k = 0;
    while (k < 4) begin
      @(negedge clk);
      k = mw.valid ? 0 : k + 1;
    end
    chk(dw0, raw);
    final_report;
  end
  initial begin
    #100us;
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
